// *** hw/pwm_pkg.sv ***
package pwm_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_MODULE_CONTROL = 4'h0;
  localparam logic [3:0] OFS_DUTY_BYTE = 4'h1;
  localparam logic [3:0] OFS_ACTIVE_DUTY = 4'h2;
  localparam logic [3:0] OFS_TIMER_SELECT = 4'h3;
  localparam logic [3:0] OFS_PERIOD_A = 4'h4;
  localparam logic [3:0] OFS_PERIOD_B = 4'h5;
  localparam logic [3:0] OFS_PERIOD_C = 4'h6;
  localparam logic [3:0] OFS_TCTRL_A = 4'h7;
  localparam logic [3:0] OFS_TCTRL_B = 4'h8;
  localparam logic [3:0] OFS_TCTRL_C = 4'h9;
  localparam logic [3:0] OFS_COUNT_A = 4'hA;
  localparam logic [3:0] OFS_COUNT_B = 4'hB;
  localparam logic [3:0] OFS_COUNT_C = 4'hC;
  localparam logic [3:0] OFS_PIN_DIR = 4'hD;
  localparam logic [3:0] OFS_MATCH_FLAGS = 4'hE;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] TCTRL_MASK = 8'h7F;
  localparam int DCB_LO = 4;
  localparam int DCB_HI = 5;
  localparam int MODE_HI = 3;
  localparam int TRUN_BIT = 2;
  localparam int CSEL_LO = 0;
  localparam logic [3:0] MODE_PWM_MASK = 4'hC;
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  localparam logic [3:0] PS_LIM_1 = 4'h0;
  localparam logic [3:0] PS_LIM_4 = 4'h3;
  localparam logic [3:0] PS_LIM_16 = 4'hF;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW = 2'b11
  } pwm_state_t;
endpackage

// *** hw/standard_pwm_channel.sv ***
module standard_pwm_channel #(
  parameter int NUM_TIMERS = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire pwm_pkg::reg_req_t reg_req,
  input wire logic sleep,
  output logic [7:0] rdata,
  output logic pwm_output_pin_o,
  output logic pwm_output_pin_oe
);
  initial begin
    if (NUM_TIMERS != 3) $error("three timers only");
  end

  logic [7:0] module_control_ff;
  logic [7:0] duty_byte_ff;
  logic [7:0] active_duty_ff;
  logic [1:0] duty_latch_ff;
  logic [7:0] timer_select_ff;
  logic [7:0] period_ff [NUM_TIMERS];
  logic [7:0] tctrl_ff [NUM_TIMERS];
  logic [7:0] count_ff [NUM_TIMERS];
  logic [3:0] pscnt_ff [NUM_TIMERS];
  logic [1:0] phase_ff;
  logic [2:0] match_flag_ff;
  logic pin_dir_ff;
  logic out_ff;
  logic [7:0] rdata_ff;
  pwm_pkg::pwm_state_t state_ff;

  logic [2:0] tick;
  logic [2:0] roll;
  logic [1:0] sel;
  logic pwm_mode;
  logic [9:0] time_base;
  logic [9:0] duty_buf;
  logic sel_roll;
  logic sel_tick;
  logic tb_adv;
  logic fall_hit;

  function automatic logic [3:0] ps_limit(input logic [1:0] ps);
    case (ps)
      pwm_pkg::PS_1: ps_limit = pwm_pkg::PS_LIM_1;
      pwm_pkg::PS_4: ps_limit = pwm_pkg::PS_LIM_4;
      default: ps_limit = pwm_pkg::PS_LIM_16;
    endcase
  endfunction

  function automatic logic wr_at(input pwm_pkg::reg_req_t r,
                                 input logic [3:0] ofs);
    wr_at = r.wr && (r.addr == ofs);
  endfunction

  // four-phase clock divider, also frozen during sleep
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= 2'h0;
    end else if (!sleep) begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // timers: prescaler gives one increment per 4*ratio clocks; the
  // postscaler bits in tctrl are stored but never used here
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      tick[i] = !sleep && tctrl_ff[i][pwm_pkg::TRUN_BIT] &&
                (phase_ff == 2'h3) &&
                (pscnt_ff[i] == ps_limit(tctrl_ff[i][1:0]));
      roll[i] = tick[i] && (count_ff[i] == period_ff[i]);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        count_ff[i] <= pwm_pkg::RST_ZERO;
        pscnt_ff[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (wr_at(reg_req, pwm_pkg::OFS_COUNT_A + 4'(i))) begin
          count_ff[i] <= reg_req.wdata;
          pscnt_ff[i] <= 4'h0;
        end else if (roll[i]) begin
          count_ff[i] <= pwm_pkg::RST_ZERO;
          pscnt_ff[i] <= 4'h0;
        end else if (tick[i]) begin
          count_ff[i] <= count_ff[i] + 8'h01;
          pscnt_ff[i] <= 4'h0;
        end else if (!sleep && tctrl_ff[i][pwm_pkg::TRUN_BIT] &&
                     phase_ff == 2'h3) begin
          pscnt_ff[i] <= pscnt_ff[i] + 4'h1;
        end
      end
    end
  end

  // match flags: a rollover in the same cycle as a clear wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_flag_ff <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (roll[i]) begin
          match_flag_ff[i] <= 1'b1;
        end else if (wr_at(reg_req, pwm_pkg::OFS_MATCH_FLAGS)) begin
          match_flag_ff[i] <= reg_req.wdata[i];
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_control_ff <= pwm_pkg::RST_ZERO;
      duty_byte_ff <= pwm_pkg::RST_ZERO;
      timer_select_ff <= pwm_pkg::RST_ZERO;
      pin_dir_ff <= 1'b1;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        period_ff[i] <= pwm_pkg::RST_PERIOD;
        tctrl_ff[i] <= pwm_pkg::RST_ZERO;
      end
    end else begin
      if (wr_at(reg_req, pwm_pkg::OFS_MODULE_CONTROL)) begin
        module_control_ff <= reg_req.wdata;
      end
      if (wr_at(reg_req, pwm_pkg::OFS_DUTY_BYTE)) begin
        duty_byte_ff <= reg_req.wdata;
      end
      if (wr_at(reg_req, pwm_pkg::OFS_TIMER_SELECT)) begin
        timer_select_ff <= reg_req.wdata;
      end
      if (wr_at(reg_req, pwm_pkg::OFS_PIN_DIR)) begin
        pin_dir_ff <= reg_req.wdata[0];
      end
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (wr_at(reg_req, pwm_pkg::OFS_PERIOD_A + 4'(i))) begin
          period_ff[i] <= reg_req.wdata;
        end
        if (wr_at(reg_req, pwm_pkg::OFS_TCTRL_A + 4'(i))) begin
          tctrl_ff[i] <= reg_req.wdata & pwm_pkg::TCTRL_MASK;
        end
      end
    end
  end

  assign sel = timer_select_ff[pwm_pkg::CSEL_LO +: 2];
  assign pwm_mode = (module_control_ff[pwm_pkg::MODE_HI -: 4] &
                     pwm_pkg::MODE_PWM_MASK) ==
                    pwm_pkg::MODE_PWM_MASK;

  always_comb begin
    logic [1:0] idx;
    logic [1:0] ext;
    idx = 2'h0;
    ext = 2'h0;
    idx = (sel < 2'(NUM_TIMERS)) ? sel : 2'h0;
    // at 1:1 the low bits follow the clock phase, else the prescaler
    if (tctrl_ff[idx][1:0] == pwm_pkg::PS_1) begin
      ext = phase_ff;
    end else if (tctrl_ff[idx][1:0] == pwm_pkg::PS_4) begin
      ext = pscnt_ff[idx][1:0];
    end else begin
      ext = pscnt_ff[idx][3:2];
    end
    time_base = {count_ff[idx], ext};
    sel_roll = roll[idx];
    sel_tick = tick[idx];
    // time base steps at the coming edge: every clock at 1:1, every
    // fourth at 1:4, every sixteenth at 1:16
    if (sleep || !tctrl_ff[idx][pwm_pkg::TRUN_BIT]) begin
      tb_adv = 1'b0;
    end else if (tctrl_ff[idx][1:0] == pwm_pkg::PS_1) begin
      tb_adv = 1'b1;
    end else if (tctrl_ff[idx][1:0] == pwm_pkg::PS_4) begin
      tb_adv = (phase_ff == 2'h3);
    end else begin
      tb_adv = (phase_ff == 2'h3) && (pscnt_ff[idx][1:0] == 2'h3);
    end
    // fall on the edge at which the time base reaches the duty value,
    // so the pulse lasts exactly duty steps
    fall_hit = tb_adv && ((time_base + 10'h001) == duty_buf);
  end

  assign duty_buf = {active_duty_ff, duty_latch_ff};

  // active duty is loaded only at rollover; bus writes never reach it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_duty_ff <= pwm_pkg::RST_ZERO;
      duty_latch_ff <= 2'h0;
    end else if (pwm_mode && sel_roll) begin
      active_duty_ff <= duty_byte_ff;
      duty_latch_ff <= module_control_ff[pwm_pkg::DCB_HI:pwm_pkg::DCB_LO];
    end
  end

  function automatic logic [9:0] next_duty(input logic [7:0] b,
                                           input logic [7:0] c);
    next_duty = {b, c[pwm_pkg::DCB_HI:pwm_pkg::DCB_LO]};
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= 1'b0;
      state_ff <= pwm_pkg::ST_IDLE;
    end else if (!pwm_mode) begin
      out_ff <= 1'b0;
      state_ff <= pwm_pkg::ST_IDLE;
    end else if (sel_roll) begin
      if (next_duty(duty_byte_ff, module_control_ff) == 10'h000) begin
        out_ff <= 1'b0;
        state_ff <= pwm_pkg::ST_LOW;
      end else begin
        out_ff <= 1'b1;
        state_ff <= pwm_pkg::ST_HIGH;
      end
    end else begin
      case (state_ff)
        pwm_pkg::ST_HIGH: begin
          // a duty beyond the period never matches, so no fall
          if (fall_hit) begin
            out_ff <= 1'b0;
            state_ff <= pwm_pkg::ST_LOW;
          end
        end
        pwm_pkg::ST_LOW: state_ff <= pwm_pkg::ST_LOW;
        pwm_pkg::ST_IDLE: state_ff <= pwm_pkg::ST_IDLE;
        default: state_ff <= pwm_pkg::ST_IDLE;
      endcase
    end
  end

  assign pwm_output_pin_o = out_ff;
  assign pwm_output_pin_oe = !pin_dir_ff &&
                             (module_control_ff != pwm_pkg::RST_ZERO);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= pwm_pkg::RST_ZERO;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        pwm_pkg::OFS_MODULE_CONTROL: rdata_ff <= module_control_ff;
        pwm_pkg::OFS_DUTY_BYTE: rdata_ff <= duty_byte_ff;
        pwm_pkg::OFS_ACTIVE_DUTY: rdata_ff <= active_duty_ff;
        pwm_pkg::OFS_TIMER_SELECT: rdata_ff <= timer_select_ff;
        pwm_pkg::OFS_PERIOD_A: rdata_ff <= period_ff[0];
        pwm_pkg::OFS_PERIOD_B: rdata_ff <= period_ff[1];
        pwm_pkg::OFS_PERIOD_C: rdata_ff <= period_ff[2];
        pwm_pkg::OFS_TCTRL_A: rdata_ff <= tctrl_ff[0];
        pwm_pkg::OFS_TCTRL_B: rdata_ff <= tctrl_ff[1];
        pwm_pkg::OFS_TCTRL_C: rdata_ff <= tctrl_ff[2];
        pwm_pkg::OFS_COUNT_A: rdata_ff <= count_ff[0];
        pwm_pkg::OFS_COUNT_B: rdata_ff <= count_ff[1];
        pwm_pkg::OFS_COUNT_C: rdata_ff <= count_ff[2];
        pwm_pkg::OFS_PIN_DIR: rdata_ff <= {7'h00, pin_dir_ff};
        pwm_pkg::OFS_MATCH_FLAGS: rdata_ff <= {5'h00, match_flag_ff};
        default: rdata_ff <= pwm_pkg::RST_ZERO;
      endcase
    end else begin
      rdata_ff <= pwm_pkg::RST_ZERO;
    end
  end
  assign rdata = rdata_ff;

  a_rollover_clears: assert property (@(posedge sys_clk) disable iff
    (!reset_n) roll[0] |=> count_ff[0] == 8'h00) else
    $error("count not cleared at rollover");
  a_rise_on_roll: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pwm_mode && sel_roll &&
    next_duty(duty_byte_ff, module_control_ff) != 10'h000 |=> out_ff)
    else $error("output not high after rollover");
  a_zero_duty_low: assert property (@(posedge sys_clk) disable iff
    (!reset_n) sel_roll &&
    next_duty(duty_byte_ff, module_control_ff) == 10'h000 |=> !out_ff)
    else $error("zero duty drove output high");
  a_duty_load: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pwm_mode && sel_roll |=> active_duty_ff ==
    $past(duty_byte_ff)) else $error("active duty not loaded");
  a_duty_hold: assert property (@(posedge sys_clk) disable iff
    (!reset_n) !sel_roll |=> $stable(active_duty_ff)) else
    $error("active duty changed mid period");
  a_fall_match: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pwm_mode && !sel_roll && out_ff && fall_hit |=> !out_ff) else
    $error("output not low at duty match");
  a_sleep_freeze: assert property (@(posedge sys_clk) disable iff
    (!reset_n) sleep && !reg_req.wr |=> $stable(count_ff[0]) &&
    $stable(out_ff)) else $error("state moved during sleep");
  a_pin_release: assert property (@(posedge sys_clk) disable iff
    (!reset_n) module_control_ff == 8'h00 |-> !pwm_output_pin_oe) else
    $error("pin driven with control cleared");
  a_tick_spacing: assert property (@(posedge sys_clk) disable iff
    (!reset_n) tick[0] |=> !tick[0] [*3]) else
    $error("timer ticks closer than four clocks");
  a_idle_low: assert property (@(posedge sys_clk) disable iff
    (!reset_n) !pwm_mode |=> !out_ff) else
    $error("output high outside pwm mode");
  a_flag_set: assert property (@(posedge sys_clk) disable iff
    (!reset_n) roll[0] |=> match_flag_ff[0]) else
    $error("match flag not set at rollover");
  a_latch_load: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pwm_mode && sel_roll |=> duty_latch_ff ==
    $past(module_control_ff[5:4])) else $error("latch not loaded");
  a_dir_input: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pin_dir_ff |-> !pwm_output_pin_oe) else
    $error("input pin driven");
  a_no_early_fall: assert property (@(posedge sys_clk) disable iff
    (!reset_n) pwm_mode && out_ff && !fall_hit && !sel_roll |=> out_ff)
    else $error("output fell before duty match");
endmodule

// *** test/pwm_load_model.sv ***
module pwm_load_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic lvl,
  output int rises,
  output int period_len,
  output int high_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;
  int since;
  int run;
  // a released pin is pulled down by the load
  assign lvl = pin_oe ? pin_o : 1'b0;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
      since <= 0;
      run <= 0;
    end else begin
      prev_ff <= lvl;
      since <= (lvl && !prev_ff) ? 1 : since + 1;
      run <= lvl ? run + 1 : 0;
      if (lvl && !prev_ff) begin
        rises <= rises + 1;
        period_len <= since;
      end
      if (!lvl && prev_ff)
        high_len <= run;
    end
  end
  initial rises = 0;
endmodule

// *** test/testbench.sv ***
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin \
  error_cnt++; $display("[FAIL] %0t %s", $time, msg); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sleep = 1'b0;
  pwm_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic pin_o;
  logic pin_oe;
  logic lvl;
  int rises;
  int period_len;
  int high_len;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] v;
  logic [7:0] c1;
  int r0;
  always #12.5 sys_clk = ~sys_clk;
  standard_pwm_channel i_standard_pwm_channel (.sys_clk(sys_clk),
    .reset_n(reset_n), .reg_req(req), .sleep(sleep), .rdata(rdata),
    .pwm_output_pin_o(pin_o), .pwm_output_pin_oe(pin_oe));
  pwm_load_model i_pwm_load_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .pin_o(pin_o), .pin_oe(pin_oe), .lvl(lvl), .rises(rises),
    .period_len(period_len), .high_len(high_len));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_rises(input int n);
    int s;
    s = rises;
    for (int k = 0; k < 3000 && rises < s + n; k++) @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    cyc(5);
    `CHK(pin_oe, 1'b0, "pin driven in reset")
    reset_n <= 1'b1;
    rd(pwm_pkg::OFS_MODULE_CONTROL, v);
    `CHK(v, 8'h00, "control reset")
    rd(pwm_pkg::OFS_PERIOD_B, v);
    `CHK(v, 8'hFF, "period reset")
    rd(pwm_pkg::OFS_PIN_DIR, v);
    `CHK(v, 8'h01, "direction reset")
    rd(4'hF, v);
    `CHK(v, 8'h00, "unmapped read")
    $display("test reset done");
  endtask
  task automatic t_setup();
    wr(pwm_pkg::OFS_PIN_DIR, 8'h01);
    wr(pwm_pkg::OFS_PERIOD_A, 8'h03);
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h2C);
    wr(pwm_pkg::OFS_DUTY_BYTE, 8'h01);
    wr(pwm_pkg::OFS_TIMER_SELECT, 8'h00);
    wr(pwm_pkg::OFS_MATCH_FLAGS, 8'h00);
    // postscaler field set to its largest value
    wr(pwm_pkg::OFS_TCTRL_A, 8'h7C);
    for (int k = 0; k < 100; k++) begin
      rd(pwm_pkg::OFS_MATCH_FLAGS, v);
      if (v[0] === 1'b1) break;
    end
    `CHK(v[0], 1'b1, "no match flag")
    wr(pwm_pkg::OFS_PIN_DIR, 8'h00);
    cyc(2);
    `CHK(pin_oe, 1'b1, "pin not driven")
    wait_rises(3);
    `CHK(period_len, 16, "period ratio 1")
    `CHK(high_len, 6, "pulse ratio 1")
    $display("test setup done");
  endtask
  task automatic t_prescale();
    logic [7:0] cfg [3] = '{8'h7D, 8'h7E, 8'h7C};
    int ratio [3] = '{4, 16, 1};
    for (int i = 0; i < 3; i++) begin
      wr(pwm_pkg::OFS_TCTRL_A, cfg[i]);
      wait_rises(3);
      `CHK(period_len, 16 * ratio[i], "prescaled period")
      `CHK(high_len, 6 * ratio[i], "prescaled pulse")
    end
    $display("test prescale done");
  endtask
  task automatic t_buffer();
    wr(pwm_pkg::OFS_DUTY_BYTE, 8'h03);
    rd(pwm_pkg::OFS_ACTIVE_DUTY, v);
    `CHK(v, 8'h01, "duty applied early")
    wait_rises(2);
    rd(pwm_pkg::OFS_ACTIVE_DUTY, v);
    `CHK(v, 8'h03, "duty not latched")
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h1C);
    wait_rises(3);
    `CHK(high_len, 13, "ten-bit duty")
    wr(pwm_pkg::OFS_ACTIVE_DUTY, 8'hAA);
    rd(pwm_pkg::OFS_ACTIVE_DUTY, v);
    `CHK(v, 8'h03, "active duty written")
    $display("test buffer done");
  endtask
  task automatic t_zero_over();
    wr(pwm_pkg::OFS_DUTY_BYTE, 8'h00);
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h0C);
    cyc(40);
    r0 = rises;
    cyc(40);
    `CHK(rises, r0, "zero duty rose")
    `CHK(lvl, 1'b0, "zero duty level")
    wr(pwm_pkg::OFS_DUTY_BYTE, 8'h05);
    cyc(40);
    r0 = rises;
    cyc(40);
    `CHK(rises, r0, "long duty edge")
    `CHK(lvl, 1'b1, "long duty level")
    $display("test zero and over done");
  endtask
  task automatic t_sleep();
    wr(pwm_pkg::OFS_DUTY_BYTE, 8'h01);
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h2C);
    wait_rises(2);
    sleep <= 1'b1;
    rd(pwm_pkg::OFS_COUNT_A, c1);
    r0 = rises;
    v[0] = lvl;
    cyc(30);
    `CHK(lvl, v[0], "level moved in sleep")
    rd(pwm_pkg::OFS_COUNT_A, v);
    `CHK(v, c1, "count moved in sleep")
    `CHK(rises, r0, "edge in sleep")
    sleep <= 1'b0;
    wait_rises(2);
    `CHK(period_len, 16, "period after wake")
    $display("test sleep done");
  endtask
  task automatic t_select();
    wr(pwm_pkg::OFS_PERIOD_B, 8'h07);
    wr(pwm_pkg::OFS_TCTRL_B, 8'h04);
    wr(pwm_pkg::OFS_PERIOD_C, 8'h01);
    wr(pwm_pkg::OFS_TCTRL_C, 8'h04);
    wr(pwm_pkg::OFS_TIMER_SELECT, 8'h01);
    wait_rises(3);
    `CHK(period_len, 32, "timer b period")
    wr(pwm_pkg::OFS_TIMER_SELECT, 8'h02);
    wait_rises(3);
    `CHK(period_len, 8, "timer c period")
    `CHK(high_len, 6, "timer c pulse")
    $display("test select done");
  endtask
  task automatic t_release();
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h00);
    cyc(2);
    `CHK(pin_oe, 1'b0, "pin kept")
    wr(pwm_pkg::OFS_MODULE_CONTROL, 8'h2C);
    wr(pwm_pkg::OFS_PIN_DIR, 8'h01);
    cyc(2);
    `CHK(pin_oe, 1'b0, "input pin driven")
    wr(pwm_pkg::OFS_PIN_DIR, 8'h00);
    cyc(5);
    do_reset();
    $display("test release done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(1);
    do_reset();
    t_setup();
    t_prescale();
    t_buffer();
    t_zero_over();
    t_sleep();
    t_select();
    t_release();
    final_report();
  end
  initial begin
    #(25 * 60000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule
